// >>> rtl/bcs_ext_bus.sv
// External bus unit with boot chip select, transfer sequencing and byte selects.
//
// Notes on behaviour
// RULE_01: After reset chip select zero is the boot select, decoding external memory from zero.
// RULE_02: Boot select is asynchronous, no bursts, fifteen wait states every transfer.
// RULE_03: Port-size strap sampled at reset: low 8-bit port, high 16-bit port.
// RULE_04: Auto-ack strap low waits for external acknowledge; high acknowledges after wait states.
// RULE_05: Boot state holds until valid bit set; selects one and two stay off before.
// RULE_06: Once set, the boot select valid bit clears only by reset.
// RULE_07: Asynchronous transfer takes three cycles at least, two with fast termination.
// RULE_08: Wide access on 16-bit port is two back-to-back halves, direction held throughout.
// RULE_09: Byte on 16-bit port: even address uses upper select and lane, odd lower.
// RULE_10: Halfword on 16-bit port asserts both active-low byte selects.
// RULE_11: Transfer lasts base cycles plus wait states: byte 4 clocks at 1, 18 at 15.
// RULE_12: 32-bit write to 16-bit port with one wait state takes eight clocks.
// RULE_13: Chip select is negated between separate accesses while the bus idles.
// RULE_14: Boot memory must hold a branch to the reset handler at address zero.
// RULE_15: Wait count is four bits, inserted between strobe assertion and termination.
// RULE_16: Bytes are big-endian: most significant byte at the lowest address.
`timescale 1ns/1ps
`include "bcs_map.svh"

module bcs_ext_bus
   import bcs_pkg::*;
(
   input wire logic clk_sys, // System clock, 40 MHz.
   input wire logic sys_rst, // Asynchronous reset, active high.
   input wire logic req_valid, // Access request.
   output logic req_ready, // Request taken when high with req_valid.
   input wire logic [31:0] req_addr, // Byte address of the access.
   input wire logic req_write, // High for a write.
   input wire bcs_size_t req_size, // Byte, halfword or word.
   input wire logic [31:0] req_wdata, // Write data, right aligned.
   output logic rsp_valid, // One-cycle end of access.
   output logic rsp_error, // No chip select decoded the address.
   output logic [31:0] rsp_rdata, // Read data, right aligned.
   input wire logic select0_mask_wr, // Software write strobe to the select zero mask register.
   input wire logic select0_mask_wr_valid, // Valid bit carried by that write.
   output logic select0_valid, // Valid bit of select zero.
   input wire logic [47:0] cs_base_hi, // Base address bits 31..16, 16 bits per select.
   input wire logic [47:0] cs_mask_hi, // Address mask bits 31..16, 16 bits per select.
   input wire logic [11:0] cs_wait, // Wait states, 4 bits per select.
   input wire logic [2:0] cs_port16, // Port is 16 bits wide, per select.
   input wire logic [2:0] cs_auto_ack, // Internal acknowledge, per select.
   input wire logic [2:0] cs_fast, // Fast termination, per select.
   input wire logic [1:0] cs12_valid, // Valid bits of selects one and two.
   input wire logic reset_port_size_pin, // Port-size strap pin.
   input wire logic reset_auto_ack_pin, // Auto-acknowledge strap pin.
   input wire logic transfer_acknowledge_n, // External acknowledge, active low.
   input wire logic [15:0] ext_data_in, // Data pins, input side.
   output logic [15:0] ext_data_out, // Data pins, output side.
   output logic ext_data_oe, // Data pins driven when high.
   output logic [31:0] ext_addr, // Address pins.
   output logic boot_chip_select_n, // Chip select zero, active low.
   output logic chip_select_one_n, // Chip select one, active low.
   output logic chip_select_two_n, // Chip select two, active low.
   output logic [1:0] byte_selects_n, // Byte selects, bit 1 is upper_byte_select, active low.
   output logic ext_rd_wr, // High for read, low for write.
   output logic ext_oe_n // Output enable to memory, active low.
);

   logic [1:0] psz_sync_reg, aack_sync_reg, ta_sync_reg;
   logic [15:0] din_s1_reg, din_s2_reg;
   logic [1:0] strap_cnt_reg, strap_cnt_next;
   logic strap_done_reg, strap_done_next, strap_p16_reg, strap_p16_next, strap_aa_reg, strap_aa_next;
   logic valid0_reg, valid0_next;
   bcs_state_t state_reg, state_next;
   logic [3:0] cnt_reg, cnt_next, ws_reg, ws_next;
   logic [1:0] beat_reg, beat_next, last_reg, last_next, sel_reg, sel_next;
   logic p16_reg, p16_next, aa_reg, aa_next, fast_reg, fast_next, wr_reg, wr_next;
   bcs_size_t size_reg, size_next;
   logic [31:0] addr_reg, addr_next, wd_reg, wd_next, acc_reg, acc_next, xaddr_reg, xaddr_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [15:0] dout_reg, dout_next;
   logic rspv_reg, rspv_next, rspe_reg, rspe_next;
   logic [2:0] hit, eff_p16, eff_aa, eff_fast, cs_en;
   logic [3:0] eff_ws [3];

   // Pins are not timed to clk_sys, so each passes two flip-flops first.
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         psz_sync_reg <= 2'h0;
         aack_sync_reg <= 2'h0;
         ta_sync_reg <= 2'h3;
         din_s1_reg <= 16'h0000;
         din_s2_reg <= 16'h0000;
      end
      else
      begin
         psz_sync_reg <= {psz_sync_reg[0], reset_port_size_pin};
         aack_sync_reg <= {aack_sync_reg[0], reset_auto_ack_pin};
         ta_sync_reg <= {ta_sync_reg[0], transfer_acknowledge_n};
         din_s1_reg <= ext_data_in;
         din_s2_reg <= din_s1_reg;
      end
   end

   // Straps are caught after release, once the synchronisers hold the pin level.
   always_comb
   begin
      strap_cnt_next = strap_cnt_reg;
      strap_done_next = strap_done_reg;
      strap_p16_next = strap_p16_reg;
      strap_aa_next = strap_aa_reg;
      valid0_next = valid0_reg | (select0_mask_wr & select0_mask_wr_valid); // see RULE_06
      if (!strap_done_reg)
      begin
         if (strap_cnt_reg == `BCS_STRAP_DELAY)
         begin
            strap_done_next = 1'b1;
            strap_p16_next = psz_sync_reg[1]; // see RULE_03
            strap_aa_next = aack_sync_reg[1]; // see RULE_04
         end
         else
         begin
            strap_cnt_next = strap_cnt_reg + 2'h1;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         strap_cnt_reg <= 2'h0;
         strap_done_reg <= 1'b0;
         strap_p16_reg <= 1'b0;
         strap_aa_reg <= 1'b0;
         valid0_reg <= 1'b0;
      end
      else
      begin
         strap_cnt_reg <= strap_cnt_next;
         strap_done_reg <= strap_done_next;
         strap_p16_reg <= strap_p16_next;
         strap_aa_reg <= strap_aa_next;
         valid0_reg <= valid0_next;
      end
   end

   assign cs_en = {cs12_valid, 1'b1};

   for (genvar g = 0; g < `BCS_NUM_CS; g++)
   begin : g_cs
      logic boot;
      logic [15:0] base, mask;
      assign boot = (g == 0) && !valid0_reg; // see RULE_05
      assign base = boot ? `BCS_BOOT_BASE : cs_base_hi[g*16 +: 16]; // see RULE_01
      assign mask = boot ? `BCS_BOOT_MASK : cs_mask_hi[g*16 +: 16];
      assign hit[g] = (boot || (valid0_reg && cs_en[g])) && (((req_addr[31:16] ^ base) & ~mask) == 16'h0000); // see RULE_05
      assign eff_ws[g] = boot ? `BCS_BOOT_WAIT : cs_wait[g*4 +: 4]; // see RULE_02
      assign eff_p16[g] = boot ? strap_p16_reg : cs_port16[g]; // see RULE_03
      assign eff_aa[g] = boot ? strap_aa_reg : cs_auto_ack[g]; // see RULE_04
      assign eff_fast[g] = boot ? 1'b0 : cs_fast[g]; // see RULE_02
   end

   // Sixteen pin bits of one beat; the most significant byte leaves first.
   function automatic logic [15:0] beat_data(input logic [31:0] wd, input logic [1:0] off, input logic wide);
      logic [31:0] sh;
      sh = wd << {off, 3'b000}; // see RULE_16
      beat_data = wide ? sh[31:16] : {sh[31:24], sh[31:24]};
   endfunction

   always_comb
   begin
      logic [1:0] s;
      logic [1:0] off;
      logic [7:0] lane;
      logic [31:0] a;
      s = `BCS_CS_BOOT;
      off = 2'h0;
      lane = 8'h00;
      a = 32'h0;
      state_next = state_reg;
      cnt_next = cnt_reg;
      ws_next = ws_reg;
      beat_next = beat_reg;
      last_next = last_reg;
      sel_next = sel_reg;
      p16_next = p16_reg;
      aa_next = aa_reg;
      fast_next = fast_reg;
      wr_next = wr_reg;
      size_next = size_reg;
      addr_next = addr_reg;
      wd_next = wd_reg;
      acc_next = acc_reg;
      xaddr_next = xaddr_reg;
      dout_next = dout_reg;
      rdata_next = rdata_reg;
      rspv_next = 1'b0;
      rspe_next = 1'b0;
      case (state_reg)
         BCS_ST_IDLE:
         begin
            if (req_valid && strap_done_reg)
            begin
               if (hit != 3'h0)
               begin
                  s = hit[0] ? `BCS_CS_BOOT : (hit[1] ? `BCS_CS_ONE : `BCS_CS_TWO);
                  sel_next = s;
                  ws_next = eff_ws[s];
                  cnt_next = eff_ws[s]; // see RULE_15
                  p16_next = eff_p16[s];
                  aa_next = eff_aa[s];
                  fast_next = eff_fast[s];
                  wr_next = req_write;
                  size_next = req_size;
                  addr_next = req_addr;
                  xaddr_next = req_addr;
                  beat_next = 2'h0;
                  acc_next = 32'h0;
                  case (req_size)
                     BCS_SZ_BYTE: wd_next = {req_wdata[7:0], 24'h000000};
                     BCS_SZ_HALF: wd_next = {req_wdata[15:0], 16'h0000};
                     default: wd_next = req_wdata;
                  endcase
                  case (req_size)
                     BCS_SZ_BYTE: last_next = 2'h0;
                     BCS_SZ_HALF: last_next = eff_p16[s] ? 2'h0 : 2'h1;
                     default: last_next = eff_p16[s] ? 2'h1 : 2'h3; // see RULE_08
                  endcase
                  dout_next = beat_data(wd_next, 2'h0, eff_p16[s] && (req_size != BCS_SZ_BYTE));
                  state_next = eff_fast[s] ? BCS_ST_DATA : BCS_ST_ADDR; // see RULE_07
               end
               else
               begin
                  rspv_next = 1'b1;
                  rspe_next = 1'b1;
                  rdata_next = 32'h0;
               end
            end
         end
         BCS_ST_ADDR:
         begin
            state_next = BCS_ST_DATA;
         end
         BCS_ST_DATA:
         begin
            if (cnt_reg != 4'h0)
            begin
               cnt_next = cnt_reg - 4'h1; // see RULE_11
            end
            else if (aa_reg || !ta_sync_reg[1])
            begin
               state_next = BCS_ST_END; // see RULE_04
            end
         end
         BCS_ST_END:
         begin
            if (p16_reg && (size_reg != BCS_SZ_BYTE))
            begin
               acc_next = {acc_reg[15:0], din_s2_reg};
            end
            else
            begin
               lane = (p16_reg && addr_reg[0]) ? din_s2_reg[7:0] : din_s2_reg[15:8]; // see RULE_09
               acc_next = {acc_reg[23:0], lane};
            end
            if (beat_reg == last_reg)
            begin
               state_next = BCS_ST_IDLE; // see RULE_13
               rspv_next = 1'b1;
               case (size_reg)
                  BCS_SZ_BYTE: rdata_next = {24'h000000, acc_next[7:0]};
                  BCS_SZ_HALF: rdata_next = {16'h0000, acc_next[15:0]};
                  default: rdata_next = acc_next;
               endcase
               if (wr_reg)
               begin
                  rdata_next = 32'h0;
               end
            end
            else
            begin
               // The next beat starts at once with the select held, so no idle gap appears.
               beat_next = beat_reg + 2'h1; // see RULE_08
               off = p16_reg ? {beat_next[0], 1'b0} : beat_next;
               a = addr_reg + {30'h0, off};
               xaddr_next = a;
               dout_next = beat_data(wd_reg, off, p16_reg);
               cnt_next = ws_reg;
               state_next = fast_reg ? BCS_ST_DATA : BCS_ST_ADDR; // see RULE_12
            end
         end
         default:
         begin
            state_next = BCS_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_reg <= BCS_ST_IDLE;
         cnt_reg <= 4'h0;
         ws_reg <= 4'h0;
         beat_reg <= 2'h0;
         last_reg <= 2'h0;
         sel_reg <= `BCS_CS_BOOT;
         p16_reg <= 1'b0;
         aa_reg <= 1'b0;
         fast_reg <= 1'b0;
         wr_reg <= 1'b0;
         size_reg <= BCS_SZ_BYTE;
         addr_reg <= 32'h0;
         wd_reg <= 32'h0;
         acc_reg <= 32'h0;
         xaddr_reg <= 32'h0;
         dout_reg <= 16'h0000;
         rdata_reg <= 32'h0;
         rspv_reg <= 1'b0;
         rspe_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         ws_reg <= ws_next;
         beat_reg <= beat_next;
         last_reg <= last_next;
         sel_reg <= sel_next;
         p16_reg <= p16_next;
         aa_reg <= aa_next;
         fast_reg <= fast_next;
         wr_reg <= wr_next;
         size_reg <= size_next;
         addr_reg <= addr_next;
         wd_reg <= wd_next;
         acc_reg <= acc_next;
         xaddr_reg <= xaddr_next;
         dout_reg <= dout_next;
         rdata_reg <= rdata_next;
         rspv_reg <= rspv_next;
         rspe_reg <= rspe_next;
      end
   end

   logic busy, strobe;
   assign busy = (state_reg != BCS_ST_IDLE);
   assign strobe = (state_reg == BCS_ST_DATA) || (state_reg == BCS_ST_END);

   assign req_ready = !busy && strap_done_reg;
   assign rsp_valid = rspv_reg;
   assign rsp_error = rspe_reg;
   assign rsp_rdata = rdata_reg;
   assign select0_valid = valid0_reg;
   assign ext_addr = xaddr_reg;
   assign ext_data_out = dout_reg;
   assign ext_data_oe = busy && wr_reg;
   assign boot_chip_select_n = !(busy && (sel_reg == `BCS_CS_BOOT)); // see RULE_13
   assign chip_select_one_n = !(busy && (sel_reg == `BCS_CS_ONE));
   assign chip_select_two_n = !(busy && (sel_reg == `BCS_CS_TWO));
   assign ext_rd_wr = !(busy && wr_reg); // see RULE_08
   assign ext_oe_n = !(strobe && !wr_reg);
   always_comb
   begin
      if (!strobe)
      begin
         byte_selects_n = `BCS_BS_NONE;
      end
      else if (p16_reg && (size_reg != BCS_SZ_BYTE))
      begin
         byte_selects_n = `BCS_BS_BOTH; // see RULE_10
      end
      else if (p16_reg && addr_reg[0])
      begin
         byte_selects_n = `BCS_BS_LOWER; // see RULE_09
      end
      else
      begin
         byte_selects_n = `BCS_BS_UPPER; // see RULE_09
      end
   end

endmodule

// >>> rtl/bcs_map.svh
// Constants of the boot chip-select external bus unit.
`ifndef BCS_MAP_SVH
`define BCS_MAP_SVH
`define BCS_NUM_CS 3
`define BCS_BOOT_BASE 16'h0000
`define BCS_BOOT_MASK 16'hffff
`define BCS_BOOT_WAIT 4'hf
`define BCS_STRAP_DELAY 2'h2
`define BCS_CS_BOOT 2'h0
`define BCS_CS_ONE 2'h1
`define BCS_CS_TWO 2'h2
`define BCS_BS_NONE 2'h3
`define BCS_BS_BOTH 2'h0
`define BCS_BS_UPPER 2'h1
`define BCS_BS_LOWER 2'h2
`endif

// >>> rtl/bcs_pkg.sv
// Types of the boot chip-select external bus unit.
package bcs_pkg;
   typedef enum logic [1:0] {BCS_SZ_BYTE, BCS_SZ_HALF, BCS_SZ_WORD} bcs_size_t;
   typedef enum logic [1:0] {BCS_ST_IDLE, BCS_ST_ADDR, BCS_ST_DATA, BCS_ST_END} bcs_state_t;
endpackage

// >>> verif/bcs_ext_bus_asserts.sv
// Concurrent checks on the pins of the external bus unit.
`timescale 1ns/1ps
`include "bcs_map.svh"
module bcs_ext_bus_asserts (
   input wire logic clk_sys, // System clock.
   input wire logic sys_rst, // Asynchronous reset.
   input wire logic rsp_valid, // End of access.
   input wire logic select0_mask_wr, // Mask register write strobe.
   input wire logic select0_mask_wr_valid, // Valid bit of that write.
   input wire logic select0_valid, // Valid bit of select zero.
   input wire logic boot_chip_select_n, // Select zero.
   input wire logic chip_select_one_n, // Select one.
   input wire logic chip_select_two_n, // Select two.
   input wire logic [1:0] byte_selects_n, // Byte selects.
   input wire logic ext_rd_wr, // Direction.
   input wire logic ext_data_oe, // Data pins driven.
   input wire logic ext_oe_n // Read strobe.
);
   logic all_hi;
   logic [7:0] low_cnt_reg;
   logic [7:0] low_cnt_next;
   assign all_hi = boot_chip_select_n && chip_select_one_n && chip_select_two_n;
   // The run length saturates, so a hung access never wraps back to a short count.
   always_comb
   begin
      low_cnt_next = all_hi ? 8'h00 : low_cnt_reg + {7'h00, low_cnt_reg != 8'hff};
   end
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         low_cnt_reg <= 8'h00;
      else
         low_cnt_reg <= low_cnt_next;
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   boot_only_a: assert property (!select0_valid |-> chip_select_one_n && chip_select_two_n)
      else $error("select one or two active before valid");
   valid_set_a: assert property (select0_mask_wr && select0_mask_wr_valid |=> select0_valid)
      else $error("valid bit did not set");
   valid_keep_a: assert property (select0_valid |=> select0_valid)
      else $error("valid bit cleared without reset");
   gap_idle_a: assert property (rsp_valid |-> all_hi && byte_selects_n == `BCS_BS_NONE && ext_oe_n)
      else $error("select held between accesses");
   end_rsp_a: assert property ($rose(all_hi) |-> rsp_valid)
      else $error("select released without response");
   min_len_a: assert property ($rose(all_hi) |-> low_cnt_reg >= 8'h02)
      else $error("transfer shorter than two cycles");
   boot_len_a: assert property ($rose(all_hi) && !select0_valid |-> low_cnt_reg >= 8'h12)
      else $error("boot transfer shorter than eighteen cycles");
   dir_hold_a: assert property (!all_hi && !$past(all_hi) |-> $stable(ext_rd_wr))
      else $error("direction changed inside an access");
   read_oe_a: assert property (!ext_oe_n |-> ext_rd_wr && !all_hi)
      else $error("read strobe outside a read");
   read_strobe_a: assert property (ext_rd_wr && byte_selects_n != `BCS_BS_NONE |-> !ext_oe_n)
      else $error("read strobe missing during a read");
   pins_drive_a: assert property (ext_data_oe |-> !ext_rd_wr && !all_hi)
      else $error("data pins driven outside a write");
endmodule

// >>> verif/bcs_ext_bus_test.sv
// Self-checking bench of the boot chip-select external bus unit.
`timescale 1ns/1ps
`include "bcs_map.svh"
module bcs_ext_bus_test
   import bcs_pkg::*;
;
   logic clk_sys = 1'b0;
   logic sys_rst, req_valid, req_ready, req_write, rsp_valid, rsp_error, select0_mask_wr, select0_mask_wr_valid;
   logic select0_valid, reset_port_size_pin, reset_auto_ack_pin, transfer_acknowledge_n, ext_data_oe, ext_rd_wr;
   logic boot_chip_select_n, chip_select_one_n, chip_select_two_n, ext_oe_n, p8;
   logic [31:0] req_addr, req_wdata, rsp_rdata, ext_addr;
   logic [47:0] cs_base_hi, cs_mask_hi;
   logic [15:0] ext_data_in, ext_data_out;
   logic [11:0] cs_wait;
   logic [2:0] cs_port16, cs_auto_ack, cs_fast;
   logic [1:0] cs12_valid, byte_selects_n;
   logic [7:0] ack_dly;
   bcs_size_t req_size;
   int n_mismatch = 0;
   int tests_run = 0;
   always #12.5 clk_sys = ~clk_sys;
   bcs_ext_bus u_bcs_ext_bus (.clk_sys, .sys_rst, .req_valid, .req_ready, .req_addr, .req_write, .req_size,
      .req_wdata, .rsp_valid, .rsp_error, .rsp_rdata, .select0_mask_wr, .select0_mask_wr_valid, .select0_valid,
      .cs_base_hi, .cs_mask_hi, .cs_wait, .cs_port16, .cs_auto_ack, .cs_fast, .cs12_valid, .reset_port_size_pin,
      .reset_auto_ack_pin, .transfer_acknowledge_n, .ext_data_in, .ext_data_out, .ext_data_oe, .ext_addr,
      .boot_chip_select_n, .chip_select_one_n, .chip_select_two_n, .byte_selects_n, .ext_rd_wr, .ext_oe_n);
   bcs_mem_model u_bcs_mem_model (.clk_sys, .sel_n(boot_chip_select_n & chip_select_one_n & chip_select_two_n),
      .port8(p8 | ~chip_select_two_n), .ext_addr, .ext_data_out, .ext_data_oe, .ext_rd_wr, .byte_selects_n,
      .ack_dly, .data_pins(ext_data_in), .ack_n(transfer_acknowledge_n));
   task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_n(input int got, input int lo, input int hi);
      tests_run++;
      if (got < lo || got > hi)
      begin
         n_mismatch++;
         $display("[ERR] %0t select low %0d cycles, expected %0d..%0d", $time, got, lo, hi);
      end
   endtask
   task automatic acc(input logic [31:0] a, input logic w, input bcs_size_t s, input logic [31:0] wd,
      input logic [31:0] ed, input logic ee, input logic [1:0] eb, input int lo, input int hi);
      int n;
      int k;
      logic [1:0] bs;
      n = 0;
      k = 0;
      bs = `BCS_BS_NONE;
      req_addr = a;
      req_write = w;
      req_size = s;
      req_wdata = wd;
      req_valid = 1'b1;
      while (!req_ready && k < 100)
      begin
         @(posedge clk_sys);
         #2;
         k++;
      end
      @(posedge clk_sys);
      #2;
      req_valid = 1'b0;
      while (!rsp_valid && k < 400)
      begin
         if (!(boot_chip_select_n && chip_select_one_n && chip_select_two_n))
         begin
            n++;
            bs = byte_selects_n;
         end
         @(posedge clk_sys);
         #2;
         k++;
      end
      chk_v({rsp_valid, rsp_error}, {1'b1, ee});
      chk_v(rsp_rdata, ed);
      chk_v(bs, eb);
      chk_n(n, lo, hi);
   endtask
   task automatic do_reset(input logic ps, input logic aa);
      sys_rst = 1'b1;
      reset_port_size_pin = ps;
      reset_auto_ack_pin = aa;
      repeat (3) @(posedge clk_sys);
      #2;
      sys_rst = 1'b0;
   endtask
   // Select zero's own entries say 8-bit and one wait state here; the boot state must ignore them.
   task automatic boot_phase();
      acc(32'h100, 1'b1, BCS_SZ_BYTE, 32'h01, 32'h0, 1'b0, `BCS_BS_UPPER, 18, 18);
      acc(32'h101, 1'b1, BCS_SZ_BYTE, 32'h23, 32'h0, 1'b0, `BCS_BS_LOWER, 18, 18);
      acc(32'h102, 1'b1, BCS_SZ_BYTE, 32'h45, 32'h0, 1'b0, `BCS_BS_UPPER, 18, 18);
      acc(32'h103, 1'b1, BCS_SZ_BYTE, 32'h67, 32'h0, 1'b0, `BCS_BS_LOWER, 18, 18);
      acc(32'h100, 1'b0, BCS_SZ_WORD, 32'h0, 32'h01234567, 1'b0, `BCS_BS_BOTH, 36, 36);
      acc(32'h00400104, 1'b1, BCS_SZ_HALF, 32'hbeef, 32'h0, 1'b0, `BCS_BS_BOTH, 18, 18);
      acc(32'h104, 1'b0, BCS_SZ_HALF, 32'h0, 32'hbeef, 1'b0, `BCS_BS_BOTH, 18, 18);
   endtask
   task automatic valid_phase();
      cs_port16 = 3'b011;
      select0_mask_wr = 1'b1;
      select0_mask_wr_valid = 1'b1;
      @(posedge clk_sys);
      #2;
      select0_mask_wr_valid = 1'b0;
      chk_v(select0_valid, 32'h1);
      @(posedge clk_sys);
      #2;
      select0_mask_wr = 1'b0;
      chk_v(select0_valid, 32'h1);
      ack_dly = 8'h06;
      acc(32'h100, 1'b1, BCS_SZ_WORD, 32'ha1b2c3d4, 32'h0, 1'b0, `BCS_BS_BOTH, 8, 8);
      acc(32'h101, 1'b0, BCS_SZ_BYTE, 32'h0, 32'hb2, 1'b0, `BCS_BS_LOWER, 4, 4);
      acc(32'h102, 1'b0, BCS_SZ_HALF, 32'h0, 32'hc3d4, 1'b0, `BCS_BS_BOTH, 4, 4);
      acc(32'h100, 1'b0, BCS_SZ_WORD, 32'h0, 32'ha1b2c3d4, 1'b0, `BCS_BS_BOTH, 8, 8);
      // Select one masks its two lowest base bits, so this address only decodes through the mask.
      acc(32'h00430020, 1'b1, BCS_SZ_HALF, 32'h1234, 32'h0, 1'b0, `BCS_BS_BOTH, 2, 2);
      acc(32'h20, 1'b0, BCS_SZ_HALF, 32'h0, 32'h1234, 1'b0, `BCS_BS_BOTH, 4, 4);
      acc(32'h00800011, 1'b1, BCS_SZ_BYTE, 32'h5a, 32'h0, 1'b0, `BCS_BS_UPPER, 7, 12);
      acc(32'h00800011, 1'b0, BCS_SZ_BYTE, 32'h0, 32'h5a, 1'b0, `BCS_BS_UPPER, 7, 12);
      acc(32'h10000000, 1'b0, BCS_SZ_BYTE, 32'h0, 32'h0, 1'b1, `BCS_BS_NONE, 0, 0);
   endtask
   task automatic strap_phase();
      p8 = 1'b1;
      do_reset(1'b0, 1'b0);
      chk_v(select0_valid, 32'h0);
      // The acknowledge comes well after the fifteen waits, so an internal acknowledge would end early.
      ack_dly = 8'h18;
      acc(32'h0, 1'b0, BCS_SZ_BYTE, 32'h0, 32'hea, 1'b0, `BCS_BS_UPPER, 25, 30);
      acc(32'h101, 1'b0, BCS_SZ_BYTE, 32'h0, 32'hb2, 1'b0, `BCS_BS_UPPER, 25, 30);
      acc(32'h100, 1'b0, BCS_SZ_WORD, 32'h0, 32'ha1b2c3d4, 1'b0, `BCS_BS_UPPER, 80, 84);
   endtask
   task automatic give_verdict();
      $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // The run needs well under a thousand cycles; four thousand leaves ample margin.
   initial
   begin
      #100000;
      n_mismatch++;
      give_verdict();
   end
   initial
   begin
      {req_valid, req_write, select0_mask_wr, select0_mask_wr_valid, p8} = 5'h00;
      {req_addr, req_wdata, ack_dly} = {64'h0, 8'hff};
      req_size = BCS_SZ_BYTE;
      {cs_base_hi, cs_mask_hi, cs_wait} = {48'h008000400000, 48'h000000030000, 12'h101};
      {cs_port16, cs_auto_ack, cs_fast, cs12_valid} = {3'b010, 3'b011, 3'b010, 2'b11};
      do_reset(1'b1, 1'b1);
      boot_phase();
      valid_phase();
      strap_phase();
      give_verdict();
   end
endmodule
bind bcs_ext_bus bcs_ext_bus_asserts u_bcs_ext_bus_asserts (.clk_sys, .sys_rst, .rsp_valid, .select0_mask_wr,
   .select0_mask_wr_valid, .select0_valid, .boot_chip_select_n, .chip_select_one_n, .chip_select_two_n,
   .byte_selects_n, .ext_rd_wr, .ext_data_oe, .ext_oe_n);

// >>> verif/bcs_mem_model.sv
// Behavioural external memory on the 16-bit data pins with a slow acknowledge.
`timescale 1ns/1ps
module bcs_mem_model (
   input wire logic clk_sys, // Bus clock.
   input wire logic sel_n, // Low while any select is low.
   input wire logic port8, // Device sits on the upper lane only.
   input wire logic [31:0] ext_addr, // Address pins.
   input wire logic [15:0] ext_data_out, // Data from the bus unit.
   input wire logic ext_data_oe, // Bus unit drives the data pins.
   input wire logic ext_rd_wr, // High for read.
   input wire logic [1:0] byte_selects_n, // Byte selects, active low.
   input wire logic [7:0] ack_dly, // Cycles from select to acknowledge.
   output logic [15:0] data_pins, // Data driven back.
   output logic ack_n // Acknowledge, active low.
);
   logic [7:0] mem [0:511];
   logic [8:0] a;
   logic [15:0] last = 16'h0000;
   int n = 0;
   initial
   begin
      foreach (mem[i]) mem[i] = 8'h00;
      mem[0] = 8'hea; // Boot image opens with a branch opcode
   end
   assign a = {ext_addr[8:1], port8 & ext_addr[0]};
   // Released pins show the inverse of the last value, so stale data can never pass as a read.
   assign data_pins = (!sel_n && ext_rd_wr) ? (port8 ? {2{mem[a]}} : {mem[a], mem[a | 9'h001]}) : ~last;
   assign ack_n = sel_n || n < int'(ack_dly); // Held low until the select rises.
   always @(posedge clk_sys)
   begin
      n <= sel_n ? 0 : n + 1;
      if (!sel_n && ext_rd_wr)
         last <= data_pins;
      if (!sel_n && ext_data_oe && !ext_rd_wr)
      begin
         if (!byte_selects_n[1])
            mem[a] <= ext_data_out[15:8];
         if (!byte_selects_n[0] && !port8)
            mem[a | 9'h001] <= ext_data_out[7:0];
      end
   end
endmodule
